// >>> rtl/tso_defines.vh
// Constants for the transport stream output block.
// Assumes inclusion by bare name from the rtl directory.
`ifndef TSO_DEFINES_VH
`define TSO_DEFINES_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define TSO_OFS_CTRL 8'h00
`define TSO_OFS_STATUS 8'h04
`define TSO_OFS_INT_STAT 8'h08
`define TSO_OFS_INT_MASK 8'h0c
`define TSO_OFS_PKT_COUNT 8'h10

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define TSO_CTRL_POL_BIT 0
`define TSO_CTRL_MARK_BIT 1
`define TSO_CTRL_SER_BIT 2
`define TSO_CTRL_ORDER_BIT 3
`define TSO_CTRL_AUX_LSB 4
`define TSO_CTRL_AUX_MSB 5
`define TSO_CTRL_RESET 6'h00

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define TSO_STAT_LOCK_BIT 0
`define TSO_STAT_BUSY_BIT 1
`define TSO_STAT_TEST_BIT 2
`define TSO_STAT_ADDR_LSB 8

// ----------------------------------------
// Interrupt bits
// ----------------------------------------
`define TSO_INT_START_BIT 0
`define TSO_INT_UNCORR_BIT 1
`define TSO_INT_LOCK_BIT 2
`define TSO_INT_RESET 3'h0

// ----------------------------------------
// Auxiliary output select codes
// ----------------------------------------
`define TSO_AUX_LOW 2'h0
`define TSO_AUX_START 2'h1
`define TSO_AUX_SYM2X 2'h2
`define TSO_AUX_SYM 2'h3

// ----------------------------------------
// Packet slot layout and timing
// ----------------------------------------
`define TSO_SLOT_BYTES 8'hcc
`define TSO_PAYLOAD_BYTES 8'hbc
`define TSO_PARITY_BYTES 8'h10
`define TSO_HDR_ERR_BYTE 8'h01
`define TSO_HDR_ERR_BIT 7
`define TSO_DEV_ADDR_HI 4'h1
`define TSO_HALF_DIV 4

`endif

// >>> rtl/tso_sync.v
// Two-flop synchroniser with rising edge detect, one lane per bit.
// Assumes d_i is asynchronous to clk_sys_i.
`timescale 1ns/1ps

module tso_sync #(
    parameter W = 1
) (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire [W-1:0] d_i,
    output wire [W-1:0] q_o,
    output wire [W-1:0] rise_o
);

reg [W-1:0] meta;
reg [W-1:0] sync;
reg [W-1:0] sync_d;

always @(posedge clk_sys_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        meta <= {W{1'b0}};
        sync <= {W{1'b0}};
        sync_d <= {W{1'b0}};
    end
    else
    begin
        meta <= d_i;
        sync <= meta;
        sync_d <= sync;
    end
end

assign q_o = sync;
assign rise_o = sync & ~sync_d;

endmodule

// >>> rtl/tso_top.v
// Transport stream output stage: packet framer, pin mapping, aux clock,
// control registers and interrupt.
// Assumes source bytes and frame lock come from logic on clk_sys_i;
// straps, test pin and the symbol clock are asynchronous pins.
//
// Notes on behaviour
// - Parallel byte or serial bit output selectable.
// - Parallel mode chooses which pin carries MSB.
// - Serial mode chooses lowest or highest pin.
// - Packet clock is byte/bit clock, polarity programmable.
// - Valid strobe high only during payload bytes.
// - Error flag high whole uncorrectable packet slot.
// - Frame lock output follows receiver synchronisation.
// - Aux output: twice symbol, symbol, packet start.
// - Aux output low after reset until selected.
// - Bus address fixed 0001 plus three straps.
// - Low reset input holds whole block reset.
// - Clock polarity defaults 0, falling edge capture.
// - Serial mode drives unused data pins low.
// - Aux select 00 low,01 start,10 2x,11 1x.
// - Mark header error bit unless marking disabled.
`timescale 1ns/1ps
`include "tso_defines.vh"

module tso_top #(
    parameter HALF_DIV = `TSO_HALF_DIV
) (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [31:0] reg_rdata_o,
    input wire src_valid_i,
    input wire src_sop_i,
    input wire [7:0] src_data_i,
    input wire src_uncorr_i,
    output wire src_ready_o,
    input wire frame_sync_i,
    input wire sym2x_clk_i,
    input wire bus_addr_strap_0_i,
    input wire bus_addr_strap_1_i,
    input wire bus_addr_strap_2_i,
    input wire factory_test_input_i,
    output reg [7:0] stream_data_pins_o,
    output reg packet_clock_out_o,
    output reg packet_valid_strobe_o,
    output reg packet_error_flag_o,
    output reg frame_lock_out_o,
    output reg aux_clock_out_o,
    output reg [6:0] bus_dev_addr_o,
    output reg irq_o
);

// ----------------------------------------
// States and local constants
// ----------------------------------------
localparam ST_IDLE = 3'b001;
localparam ST_PAY = 3'b010;
localparam ST_PAR = 3'b100;
localparam [7:0] LAST_PAY = `TSO_PAYLOAD_BYTES - 8'h01;
localparam [7:0] LAST_SLOT = `TSO_SLOT_BYTES - 8'h01;

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
wire [3:0] pins_sync;
wire sym2x_sync;
wire sym2x_rise;

tso_sync #(
    .W(4)
) u_pin_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .d_i({factory_test_input_i, bus_addr_strap_2_i, bus_addr_strap_1_i, bus_addr_strap_0_i}),
    .q_o(pins_sync),
    .rise_o()
);

tso_sync #(
    .W(1)
) u_sym_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .d_i(sym2x_clk_i),
    .q_o(sym2x_sync),
    .rise_o(sym2x_rise)
);

// ----------------------------------------
// Control registers
// ----------------------------------------
reg [5:0] ctrl;
reg [2:0] int_stat;
reg [2:0] int_mask;
reg [31:0] pkt_count;
reg [1:0] cap_cnt;
wire pol = ctrl[`TSO_CTRL_POL_BIT];
wire mark_off = ctrl[`TSO_CTRL_MARK_BIT];
wire serial = ctrl[`TSO_CTRL_SER_BIT];
wire order = ctrl[`TSO_CTRL_ORDER_BIT];
wire [1:0] aux_sel = ctrl[`TSO_CTRL_AUX_MSB:`TSO_CTRL_AUX_LSB];

// ----------------------------------------
// Framer state
// ----------------------------------------
reg [2:0] state;
reg [HALF_DIV-1:0] div_cnt;
reg ph;
reg [7:0] cur_byte;
reg [7:0] byte_idx;
reg [2:0] bit_idx;
reg valid;
reg pkt_err;
reg lock_d;
reg toggle_sym;
reg [2:0] next_events;

wire tick = (div_cnt == {HALF_DIV{1'b0}});
wire launch = tick & ~ph;
wire byte_end = ~serial | (bit_idx == 3'h7);
wire take_first = (state == ST_IDLE) & src_valid_i & src_sop_i;
wire take_next = (state == ST_PAY) & byte_end & (byte_idx != LAST_PAY) & src_valid_i;
wire stall = (state == ST_PAY) & byte_end & (byte_idx != LAST_PAY) & ~src_valid_i;
wire [7:0] next_idx = take_first ? 8'h00 : byte_idx + 8'h01;

assign src_ready_o = launch & (take_first | take_next);

// Header error bit is forced only for uncorrectable packets
// header error marking
wire uncorr_now = take_first ? src_uncorr_i : pkt_err;
wire mark = ~mark_off & uncorr_now & (next_idx == `TSO_HDR_ERR_BYTE);
wire [7:0] in_byte = src_data_i | (mark ? 8'h80 : 8'h00);

// ----------------------------------------
// Byte and bit sequencer
// ----------------------------------------
// async reset everywhere
always @(posedge clk_sys_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        state <= ST_IDLE;
        div_cnt <= {HALF_DIV{1'b0}};
        ph <= 1'b0;
        cur_byte <= 8'h00;
        byte_idx <= 8'h00;
        bit_idx <= 3'h0;
        valid <= 1'b0;
        pkt_err <= 1'b0;
    end
    else
    begin
        div_cnt <= tick ? HALF_DIV[HALF_DIV-1:0] - {{(HALF_DIV-1){1'b0}}, 1'b1} : div_cnt - 1'b1;
        // clock phase ph holds low while source stalls
        if (tick & ph)
            ph <= 1'b0;
        else if (launch & ~stall)
            ph <= 1'b1;
        if (launch & ~stall)
        begin
            case (state)
                ST_IDLE:
                begin
                    bit_idx <= 3'h0;
                    byte_idx <= 8'h00;
                    if (take_first)
                    begin
                        state <= ST_PAY;
                        cur_byte <= in_byte;
                        valid <= 1'b1;
                        pkt_err <= src_uncorr_i;
                    end
                    else
                    begin
                        cur_byte <= 8'h00;
                        valid <= 1'b0;
                        pkt_err <= 1'b0;
                    end
                end
                ST_PAY:
                begin
                    if (!byte_end)
                    begin
                        bit_idx <= bit_idx + 3'h1;
                        cur_byte <= {cur_byte[6:0], 1'b0};
                    end
                    else if (byte_idx == LAST_PAY)
                    begin
                        state <= ST_PAR;
                        bit_idx <= 3'h0;
                        byte_idx <= `TSO_PAYLOAD_BYTES;
                        cur_byte <= 8'h00;
                        valid <= 1'b0;
                    end
                    else
                    begin
                        bit_idx <= 3'h0;
                        byte_idx <= next_idx;
                        cur_byte <= in_byte;
                    end
                end
                ST_PAR:
                begin
                    bit_idx <= byte_end ? 3'h0 : bit_idx + 3'h1;
                    if (byte_end)
                    begin
                        byte_idx <= next_idx;
                        if (byte_idx == LAST_SLOT)
                        begin
                            state <= ST_IDLE;
                            pkt_err <= 1'b0;
                        end
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end
end

// ----------------------------------------
// Pin mapping
// ----------------------------------------
wire [7:0] rev_byte;
genvar gi;
generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_rev
        assign rev_byte[gi] = cur_byte[7-gi];
    end
endgenerate

reg [7:0] next_pins;
always @*
begin
    next_pins = 8'h00;
    if (serial)
    begin
        if (order)
            next_pins[7] = cur_byte[7];
        else
            next_pins[0] = cur_byte[7];
    end
    else if (order)
        next_pins = rev_byte;
    else
        next_pins = cur_byte;
end

reg next_aux;
always @*
begin
    case (aux_sel)
        `TSO_AUX_START:
            next_aux = (state == ST_PAY) & (byte_idx == 8'h00);
        `TSO_AUX_SYM2X:
            next_aux = sym2x_sync;
        `TSO_AUX_SYM:
            next_aux = toggle_sym;
        default:
            next_aux = 1'b0;
    endcase
end

// ----------------------------------------
// Registered outputs
// ----------------------------------------
always @(posedge clk_sys_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        stream_data_pins_o <= 8'h00;
        packet_clock_out_o <= 1'b0;
        packet_valid_strobe_o <= 1'b0;
        packet_error_flag_o <= 1'b0;
        frame_lock_out_o <= 1'b0;
        aux_clock_out_o <= 1'b0;
        toggle_sym <= 1'b0;
        lock_d <= 1'b0;
        irq_o <= 1'b0;
    end
    else
    begin
        stream_data_pins_o <= next_pins;
        packet_clock_out_o <= ph ^ pol;
        packet_valid_strobe_o <= valid;
        packet_error_flag_o <= pkt_err;
        frame_lock_out_o <= frame_sync_i;
        lock_d <= frame_sync_i;
        if (sym2x_rise)
            toggle_sym <= ~toggle_sym;
        aux_clock_out_o <= next_aux;
        irq_o <= |(int_stat & int_mask);
    end
end

// ----------------------------------------
// Address strap capture
// ----------------------------------------
always @(posedge clk_sys_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        cap_cnt <= 2'h0;
        bus_dev_addr_o <= 7'h00;
    end
    else if (cap_cnt != 2'h3)
    begin
        cap_cnt <= cap_cnt + 2'h1;
        bus_dev_addr_o <= {`TSO_DEV_ADDR_HI, pins_sync[2:0]};
    end
end

// ----------------------------------------
// Register bus and interrupts
// ----------------------------------------
always @*
begin
    next_events = 3'h0;
    next_events[`TSO_INT_START_BIT] = src_ready_o & take_first;
    next_events[`TSO_INT_UNCORR_BIT] = src_ready_o & take_first & src_uncorr_i;
    next_events[`TSO_INT_LOCK_BIT] = lock_d ^ frame_sync_i;
end

wire wr_stat = reg_wr_i & (reg_addr_i == `TSO_OFS_INT_STAT);

always @(posedge clk_sys_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        ctrl <= `TSO_CTRL_RESET;
        int_stat <= `TSO_INT_RESET;
        int_mask <= `TSO_INT_RESET;
        pkt_count <= 32'h0000_0000;
        reg_rdata_o <= 32'h0000_0000;
    end
    else
    begin
        if (next_events[`TSO_INT_START_BIT])
            pkt_count <= pkt_count + 32'h0000_0001;
        // Set wins over a same-cycle write-one clear
        int_stat <= (int_stat & ~(wr_stat ? reg_wdata_i[2:0] : 3'h0)) | next_events;
        if (reg_wr_i)
        begin
            if (reg_addr_i == `TSO_OFS_CTRL)
                ctrl <= reg_wdata_i[5:0];
            else if (reg_addr_i == `TSO_OFS_INT_MASK)
                int_mask <= reg_wdata_i[2:0];
        end
        reg_rdata_o <= 32'h0000_0000;
        if (reg_rd_i)
        begin
            if (reg_addr_i == `TSO_OFS_CTRL)
                reg_rdata_o <= {26'h000_0000, ctrl};
            else if (reg_addr_i == `TSO_OFS_STATUS)
                reg_rdata_o <= {17'h0_0000, bus_dev_addr_o, 5'h00, pins_sync[3], ~(state == ST_IDLE),
                                frame_lock_out_o};
            else if (reg_addr_i == `TSO_OFS_INT_STAT)
                reg_rdata_o <= {29'h0000_0000, int_stat};
            else if (reg_addr_i == `TSO_OFS_INT_MASK)
                reg_rdata_o <= {29'h0000_0000, int_mask};
            else if (reg_addr_i == `TSO_OFS_PKT_COUNT)
                reg_rdata_o <= pkt_count;
        end
    end
end

endmodule

// >>> verif/tso_top_monitor.sv
// Checker on tso_top ports; the control word is shadowed from bus writes.
// Assumes a bind into tso_top and no mid-payload source stall.
`timescale 1ns/1ps
`include "tso_defines.vh"

module tso_top_monitor #(
    parameter HALF_DIV = 4
) (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire frame_sync_i,
    input wire bus_addr_strap_0_i,
    input wire bus_addr_strap_1_i,
    input wire bus_addr_strap_2_i,
    input wire [7:0] stream_data_pins_o,
    input wire packet_clock_out_o,
    input wire packet_valid_strobe_o,
    input wire packet_error_flag_o,
    input wire frame_lock_out_o,
    input wire aux_clock_out_o,
    input wire [6:0] bus_dev_addr_o,
    input wire irq_o
);
    reg [5:0] ctrl;
    reg [3:0] up;
    reg [4:0] quiet;
    reg [7:0] run;
    reg pclk_q;
    wire pclk_tog = packet_clock_out_o != pclk_q;

    // ----
    // Shadow control, time since release and since last write
    // ----
    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl <= 6'h00;
            up <= 4'h0;
            quiet <= 5'h1f;
            run <= 8'h00;
            pclk_q <= 1'b0;
        end
        else
        begin
            if (reg_wr_i && reg_addr_i == `TSO_OFS_CTRL)
                ctrl <= reg_wdata_i[5:0];
            up <= (up == 4'hf) ? up : up + 4'h1;
            quiet <= reg_wr_i ? 5'h00 : (quiet == 5'h1f) ? quiet : quiet + 5'h01;
            run <= pclk_tog ? 8'h00 : run + 8'h01;
            pclk_q <= packet_clock_out_o;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    reset_quiet_a:
    assert property (disable iff (1'b0) !rst_n_i |-> !packet_valid_strobe_o && !irq_o && stream_data_pins_o == 8'h00)
        else $error("output active in reset");
    lock_follow_a:
    assert property (up > 4'h1 |-> frame_lock_out_o == $past(frame_sync_i))
        else $error("frame lock does not follow");
    dev_addr_a:
    assert property (up > 4'h5 |-> bus_dev_addr_o == {4'h1, bus_addr_strap_2_i, bus_addr_strap_1_i, bus_addr_strap_0_i})
        else $error("bus address wrong");
    err_stable_a:
    assert property (packet_valid_strobe_o && $past(packet_valid_strobe_o) |-> $stable(packet_error_flag_o))
        else $error("error flag moved in packet");
    pclk_half_a:
    assert property (pclk_tog && up == 4'hf && quiet > 5'h0f |-> run == HALF_DIV - 1)
        else $error("packet clock half period");
    data_hold_a:
    assert property (pclk_tog && packet_clock_out_o == ctrl[0] && quiet > 5'h07 |-> $stable(stream_data_pins_o))
        else $error("data moved at capture edge");
    ser_unused_a:
    assert property (ctrl[2] && packet_valid_strobe_o && quiet > 5'h07
        |-> (ctrl[3] ? stream_data_pins_o[6:0] : stream_data_pins_o[7:1]) == 7'h00)
        else $error("unused serial pin high");
    aux_low_a:
    assert property (ctrl[5:4] == 2'h0 && quiet > 5'h03 |-> !aux_clock_out_o)
        else $error("aux output not low");
endmodule

bind tso_top tso_top_monitor #(.HALF_DIV(HALF_DIV)) mon_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .frame_sync_i(frame_sync_i),
    .bus_addr_strap_0_i(bus_addr_strap_0_i), .bus_addr_strap_1_i(bus_addr_strap_1_i),
    .bus_addr_strap_2_i(bus_addr_strap_2_i), .stream_data_pins_o(stream_data_pins_o),
    .packet_clock_out_o(packet_clock_out_o), .packet_valid_strobe_o(packet_valid_strobe_o),
    .packet_error_flag_o(packet_error_flag_o), .frame_lock_out_o(frame_lock_out_o),
    .aux_clock_out_o(aux_clock_out_o), .bus_dev_addr_o(bus_dev_addr_o), .irq_o(irq_o));

// >>> verif/tso_demux_model.sv
// Downstream demultiplexer model: takes the pins on the capture edge.
// Assumes pol_i mirrors the clock polarity control bit.
`timescale 1ns/1ps

module tso_demux_model (
    input wire clk_sys_i,
    input wire pol_i,
    input wire pclk_i,
    input wire [7:0] pins_i,
    input wire vld_i,
    input wire err_i,
    output reg cap_o,
    output reg [9:0] word_o
);
    reg pclk_q;

    initial
    begin
        pclk_q = 1'b0;
        cap_o = 1'b0;
        word_o = 10'h000;
    end

    // capture on falling edge for 0
    always @(posedge clk_sys_i)
    begin
        pclk_q <= pclk_i;
        cap_o <= (pclk_i != pclk_q) && (pclk_i == pol_i);
        word_o <= {vld_i, err_i, pins_i};
    end
endmodule

// >>> verif/tb.sv
// Bench for tso_top: register tasks, source feeder, demux model watch.
// Assumes the default HALF_DIV, so one parallel byte time is 8 clocks.
`timescale 1ns/1ps
`include "tso_defines.vh"

module tb;
    reg clk_sys_i, rst_n_i, reg_wr, reg_rd, sv, sop, su, sync, sym, sym_q, s0, s1, s2, rd_seen, aux_q;
    reg [7:0] addr, sd;
    reg [31:0] wd;
    reg [5:0] ctrl;
    reg [63:0] rx;
    reg [9:0] sq[$];
    reg [63:0] rq[$];
    wire [31:0] rdata;
    wire [7:0] pins;
    wire [6:0] dev;
    wire [9:0] word;
    wire rdy, pclk, vld, err, lock, aux, irq, cap;
    integer miscompares, n_tests, aux_hi, aux_rise, sym_rise, i, k, n;
    localparam [27:0] CFG = {7'h4d, 7'h34, 7'h6b, 7'h50};

    tso_top dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wd),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .src_valid_i(sv), .src_sop_i(sop),
        .src_data_i(sd), .src_uncorr_i(su), .src_ready_o(rdy), .frame_sync_i(sync), .sym2x_clk_i(sym),
        .bus_addr_strap_0_i(s0), .bus_addr_strap_1_i(s1), .bus_addr_strap_2_i(s2), .factory_test_input_i(1'b0),
        .stream_data_pins_o(pins), .packet_clock_out_o(pclk), .packet_valid_strobe_o(vld),
        .packet_error_flag_o(err), .frame_lock_out_o(lock), .aux_clock_out_o(aux), .bus_dev_addr_o(dev),
        .irq_o(irq));
    tso_demux_model mdl_u (.clk_sys_i(clk_sys_i), .pol_i(ctrl[0]), .pclk_i(pclk), .pins_i(pins), .vld_i(vld),
        .err_i(err), .cap_o(cap), .word_o(word));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    initial
    begin
        sym = 1'b0;
        forever #62.5 sym = ~sym;
    end

    // ----
    // Checking and bus tasks
    // ----
    task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
        n_tests = n_tests + 1;
        if (e !== g)
        begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    end
    endtask
    task results;
    begin
        if (miscompares == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    task fail_out;
    begin
        chk("wait bound", 1, 0);
        results;
    end
    endtask
    task bus_wr(input [7:0] a, input [31:0] v);
    begin
        addr <= a;
        wd <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr <= 1'b0;
        @(posedge clk_sys_i);
    end
    endtask
    task bus_rd(input [7:0] a, input [31:0] e, input [31:0] m);
    begin
        rq.push_back({m, e});
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd <= 1'b0;
        @(posedge clk_sys_i);
    end
    endtask
    function [7:0] rev(input [7:0] v);
        integer j;
    begin
        for (j = 0; j < 8; j = j + 1)
            rev[j] = v[7 - j];
    end
    endfunction
    task send(input u);
        reg [7:0] d;
    begin
        for (i = 0; i < 188; i = i + 1)
        begin
            d = 8'($urandom);
            sv <= 1'b1;
            sop <= (i == 0);
            sd <= d;
            su <= u;
            if (i == 1 && u && !ctrl[1])
                d[7] = 1'b1;
            if (!ctrl[2])
                sq.push_back({1'b1, u, ctrl[3] ? rev(d) : d});
            for (k = 7; k >= 0 && ctrl[2]; k = k - 1)
                sq.push_back({1'b1, u, ctrl[3] ? {d[k], 7'h00} : {7'h00, d[k]}});
            k = 0;
            @(negedge clk_sys_i);
            while (rdy !== 1'b1)
            begin
                k = k + 1;
                if (k > 100)
                    fail_out;
                @(negedge clk_sys_i);
            end
            @(posedge clk_sys_i);
        end
        sv <= 1'b0;
    end
    endtask

    always @(negedge clk_sys_i)
    begin
        if (rd_seen)
        begin
            rx = rq.pop_front();
            chk("reg_rdata_o", rx[31:0], rdata & rx[63:32]);
        end
        rd_seen = reg_rd;
        if (cap && word[9])
            chk("stream word", (sq.size() > 0) ? sq.pop_front() : 10'h3ff, word);
        aux_hi = aux_hi + aux;
        aux_rise = aux_rise + (aux && !aux_q);
        sym_rise = sym_rise + (sym && !sym_q);
        aux_q = aux;
        sym_q = sym;
    end

    initial
    begin
        void'($urandom(32'h6b32));
        miscompares = 0;
        n_tests = 0;
        rst_n_i = 1'b0;
        {reg_wr, reg_rd, sv, sop, su, sync, rd_seen, aux_q, sym_q} = 9'h000;
        {addr, sd, wd, ctrl} = 54'h0;
        {aux_hi, aux_rise, sym_rise} = 96'h0;
        {s2, s1, s0} = 3'($urandom);
        repeat (6) @(posedge clk_sys_i);
        chk("reset outputs", 0, {vld, irq, pins});
        rst_n_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        chk("bus_dev_addr_o", {4'h1, s2, s1, s0}, dev);
        bus_rd(`TSO_OFS_CTRL, 0, 32'h3f);
        sync <= 1'b1;
        bus_rd(8'h20, 0, 32'hffff_ffff);
        repeat (4) @(posedge clk_sys_i);
        chk("frame_lock_out_o", 1, lock);
        bus_rd(`TSO_OFS_STATUS, {17'h0, 4'h1, s2, s1, s0, 8'h01}, 32'h7f05);
        bus_wr(`TSO_OFS_INT_STAT, 7);
        bus_rd(`TSO_OFS_INT_STAT, 0, 7);
        for (n = 0; n < 4; n = n + 1)
        begin
            ctrl = CFG[n * 7 +: 6];
            bus_wr(`TSO_OFS_CTRL, {26'h0, ctrl});
            repeat (8) @(posedge clk_sys_i);
            {aux_hi, aux_rise, sym_rise} = 96'h0;
            send(CFG[n * 7 + 6]);
            k = 0;
            while (sq.size() > 0)
            begin
                k = k + 1;
                if (k > 20000)
                    fail_out;
                @(posedge clk_sys_i);
            end
            repeat (ctrl[2] ? 1200 : 200) @(posedge clk_sys_i);
            k = aux_rise * (ctrl[4] ? 2 : 1) - sym_rise;
            case (ctrl[5:4])
                2'h0: chk("aux low", 0, aux_hi);
                2'h1: chk("aux start", 8, aux_hi);
                default: chk("aux clock", 1, k >= -3 && k <= 3);
            endcase
            if (n == 0)
            begin
                bus_rd(`TSO_OFS_INT_STAT, 3, 7);
                chk("irq masked", 0, irq);
                bus_wr(`TSO_OFS_INT_MASK, 1);
                repeat (2) @(posedge clk_sys_i);
                chk("irq set", 1, irq);
                bus_wr(`TSO_OFS_INT_STAT, 1);
                repeat (2) @(posedge clk_sys_i);
                chk("irq clear", 0, irq);
                bus_rd(`TSO_OFS_INT_STAT, 2, 7);
            end
        end
        sync <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        chk("frame_lock_out_o", 0, lock);
        bus_rd(`TSO_OFS_PKT_COUNT, 4, 32'hffff_ffff);
        bus_rd(`TSO_OFS_INT_STAT, 4, 4);
        repeat (4) @(posedge clk_sys_i);
        results;
    end
endmodule
